/* src/aer_pkg.sv */
// Package for the uncorrectable error mask, severity and status bank
package aer_pkg;

  // Register byte addresses
  localparam logic [11:0] OFS_STATUS   = 12'h104;
  localparam logic [11:0] OFS_MASK     = 12'h108;
  localparam logic [11:0] OFS_SEVERITY = 12'h10C;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h140;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h144;

  // Event bit positions
  localparam int BIT_UNUSED0   = 0;
  localparam int BIT_LINK_PROT = 4;
  localparam int BIT_SURPRISE  = 5;
  localparam int BIT_POISONED  = 12;
  localparam int BIT_CREDIT    = 13;
  localparam int BIT_COMPL_TO  = 14;
  localparam int BIT_COMPL_AB  = 15;
  localparam int BIT_UNEXP_CPL = 16;
  localparam int BIT_RX_OVFL   = 17;
  localparam int BIT_MALFORMED = 18;
  localparam int BIT_ECRC      = 19;
  localparam int BIT_UNSUP_REQ = 20;

  // Writable bits of each register; all other bits read zero
  localparam logic [31:0] MASK_RW_BITS   = 32'h001F_3031;
  localparam logic [31:0] SEV_RW_BITS    = 32'h001F_3031;
  localparam logic [31:0] STATUS_BITS    = 32'h001F_3030;
  localparam logic [31:0] EVENT_BITS     = 32'h001F_3030;

  // Reset values
  localparam logic [31:0] MASK_RESET     = 32'h0000_0000;
  localparam logic [31:0] SEV_RESET      = 32'h0006_2030;
  localparam logic [31:0] STATUS_RESET   = 32'h0000_0000;
  localparam logic [1:0]  IRQ_RESET      = 2'h0;

  // Interrupt status bits
  localparam int IRQ_FATAL    = 0;
  localparam int IRQ_NONFATAL = 1;

  // Error report sent upstream
  typedef struct packed {
    logic        valid;
    logic        fatal;
    logic [4:0]  bit_index;
  } aer_report_t;

endpackage : aer_pkg

/* src/aer_uncorr_bank.sv */
// Uncorrectable error mask, severity, status registers with APB slave
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
// Contract
// - Masked ECRC event, bit 19, neither logged nor reported.
// - Masked unsupported request event, bit 20, neither logged nor reported.
// - Severity register at offset 0x10C, sticky read-write bit per event except bits 14 and 15.
// - Unmasked event other than bits 14 and 15 reports fatal if severity one, else non-fatal.
// - Severity bits 4 and 5 reset to one.
// - Severity bit 13 read-write, resets to one.
// - Severity bit 17 read-write, resets to one.
// - Severity bit 18 read-write, resets to one.
// - Severity bit 12 read-write, resets to zero.
// - Severity bit 16 read-write, resets to zero.
// - Severity bits 19 and 20 read-write, reset to zero.
// - Severity bit 14 read-only zero.
// - Severity bit 15 read-only zero.
// - Severity bit 0 sticky read-write, reset zero, no effect.
// - Status bits set on event, except bits 14 and 15, cleared by writing one; mask at 0x108.
// - ECRC status bit set when end-to-end CRC error detected.
module aer_uncorr_bank (
  // Clock and resets
  input  wire logic                 clk_i,
  input  wire logic                 srst_i,
  input  wire logic                 hot_reset_i,
  // APB slave
  input  wire logic                 psel_i,
  input  wire logic                 penable_i,
  input  wire logic                 pwrite_i,
  input  wire logic [11:0]          paddr_i,
  input  wire logic [31:0]          pwdata_i,
  input  wire logic [3:0]           pstrb_i,
  output logic      [31:0]          prdata_o,
  output logic                      pready_o,
  output logic                      pslverr_o,
  // Detected events, one-cycle pulses per bit
  input  wire logic [31:0]          event_i,
  // Report toward the root complex
  output aer_pkg::aer_report_t      report_o,
  // Interrupt
  output logic                      irq_o
);

  //////////////////////////////////////////////////////////////////////////
  // Storage
  logic [31:0] uncorr_err_mask_reg;
  logic [31:0] uncorr_err_severity_reg;
  logic [31:0] uncorr_err_status_reg;
  logic [1:0]  irq_status;
  logic [1:0]  irq_mask;

  // Byte-enable merge of write data
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Bus decode; zero-wait-state slave
  logic acc;
  logic wr;
  logic known;
  logic [31:0] wmask;
  assign acc   = psel_i & penable_i;
  assign wr    = acc & pwrite_i;
  assign wmask = merge(32'h0000_0000, 32'hFFFF_FFFF, pstrb_i);
  assign known = (paddr_i == aer_pkg::OFS_STATUS) | (paddr_i == aer_pkg::OFS_MASK) |
                 (paddr_i == aer_pkg::OFS_SEVERITY) | (paddr_i == aer_pkg::OFS_IRQ_STAT) |
                 (paddr_i == aer_pkg::OFS_IRQ_MASK);
  assign pready_o  = 1'b1;
  assign pslverr_o = acc & ~known;

  //////////////////////////////////////////////////////////////////////////
  // Event qualification: masked events never log nor report
  logic [31:0] live_ev;
  assign live_ev = event_i & aer_pkg::EVENT_BITS & ~uncorr_err_mask_reg;

  // Sticky mask; only fundamental reset restores it, hot reset does not
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      uncorr_err_mask_reg <= aer_pkg::MASK_RESET;
    end else if (wr && paddr_i == aer_pkg::OFS_MASK) begin
      uncorr_err_mask_reg <= merge(uncorr_err_mask_reg, pwdata_i, pstrb_i)
                             & aer_pkg::MASK_RW_BITS;
    end
  end

  // Sticky severity; bits 14, 15 and reserved stay zero
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      uncorr_err_severity_reg <= aer_pkg::SEV_RESET;
    end else if (wr && paddr_i == aer_pkg::OFS_SEVERITY) begin
      uncorr_err_severity_reg <= merge(uncorr_err_severity_reg, pwdata_i, pstrb_i)
                                 & aer_pkg::SEV_RW_BITS;
    end
  end

  // Sticky status; a new event beats a simultaneous clear
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      uncorr_err_status_reg <= aer_pkg::STATUS_RESET;
    end else begin
      uncorr_err_status_reg <= ((wr && paddr_i == aer_pkg::OFS_STATUS) ?
                                (uncorr_err_status_reg & ~(pwdata_i & wmask)) :
                                uncorr_err_status_reg) | live_ev;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Report: lowest live_ev bit gives the index when several arrive together; fatal if any is fatal
  logic [31:0] sev_ev;
  assign sev_ev = live_ev & uncorr_err_severity_reg;
  always_ff @(posedge clk_i) begin
    if (srst_i || hot_reset_i) begin
      report_o <= '0;
    end else begin
      report_o.valid     <= |live_ev;
      report_o.fatal     <= |sev_ev;
      report_o.bit_index <= 5'd0;
      for (int i = 31; i >= 0; i--) begin
        if (live_ev[i]) begin
          report_o.bit_index <= 5'(i);
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Interrupt status (write one to clear, set wins) and mask
  logic [1:0] irq_set;
  assign irq_set = {|(live_ev & ~uncorr_err_severity_reg), |sev_ev};
  always_ff @(posedge clk_i) begin
    if (srst_i || hot_reset_i) begin
      irq_status <= aer_pkg::IRQ_RESET;
    end else begin
      irq_status <= ((wr && paddr_i == aer_pkg::OFS_IRQ_STAT && pstrb_i[0]) ?
                     (irq_status & ~pwdata_i[1:0]) : irq_status) | irq_set;
    end
  end
  always_ff @(posedge clk_i) begin
    if (srst_i || hot_reset_i) begin
      irq_mask <= aer_pkg::IRQ_RESET;
    end else if (wr && paddr_i == aer_pkg::OFS_IRQ_MASK && pstrb_i[0]) begin
      irq_mask <= pwdata_i[1:0];
    end
  end
  assign irq_o = |(irq_status & irq_mask);

  //////////////////////////////////////////////////////////////////////////
  // Read mux, registered data; unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      case (paddr_i)
        aer_pkg::OFS_STATUS:   prdata_o <= uncorr_err_status_reg;
        aer_pkg::OFS_MASK:     prdata_o <= uncorr_err_mask_reg;
        aer_pkg::OFS_SEVERITY: prdata_o <= uncorr_err_severity_reg;
        aer_pkg::OFS_IRQ_STAT: prdata_o <= {30'h0, irq_status};
        aer_pkg::OFS_IRQ_MASK: prdata_o <= {30'h0, irq_mask};
        default:               prdata_o <= 32'h0000_0000;
      endcase
    end
  end

endmodule // aer_uncorr_bank

/* testbench/aer_bank_asserts.sv */
// Port checker for the uncorrectable error bank
`timescale 1ns/1ps
module aer_bank_asserts (
  // Watched ports
  input wire logic clk_i, srst_i, hot_reset_i, psel_i, penable_i, pwrite_i, pslverr_o,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] prdata_o, event_i,
  input wire aer_pkg::aer_report_t report_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // Access phase and address decode
  logic acc, ok;
  assign acc = psel_i && penable_i;
  assign ok = paddr_i inside {aer_pkg::OFS_STATUS, aer_pkg::OFS_MASK, aer_pkg::OFS_SEVERITY,
    aer_pkg::OFS_IRQ_STAT, aer_pkg::OFS_IRQ_MASK};
  // Read: setup cycle, then access cycle
  sequence s_rd(a); psel_i && !penable_i && !pwrite_i && paddr_i == a ##1 acc; endsequence
  property p_bad; acc && !ok |-> pslverr_o; endproperty
  a_bad: assert property (p_bad) else $error("unmapped access accepted");
  property p_sev; acc && paddr_i == aer_pkg::OFS_SEVERITY |-> !pslverr_o; endproperty
  a_sev: assert property (p_sev) else $error("severity access refused");
  property p_sev_rsv;
    s_rd(aer_pkg::OFS_SEVERITY) |-> (prdata_o & ~aer_pkg::SEV_RW_BITS) == 32'h0; endproperty
  a_sev_rsv: assert property (p_sev_rsv) else $error("severity fixed bit set");
  property p_msk_rsv;
    s_rd(aer_pkg::OFS_MASK) |-> (prdata_o & ~aer_pkg::MASK_RW_BITS) == 32'h0; endproperty
  a_msk_rsv: assert property (p_msk_rsv) else $error("mask fixed bit set");
  property p_cause; report_o.valid |-> |($past(event_i) & (32'h1 << report_o.bit_index));
  endproperty
  a_cause: assert property (p_cause) else $error("report without its event");
  property p_legal;
    report_o.valid |-> |(aer_pkg::EVENT_BITS & (32'h1 << report_o.bit_index)); endproperty
  a_legal: assert property (p_legal) else $error("report for inert bit");
  property p_quiet; !(|(event_i & aer_pkg::EVENT_BITS)) |=> !report_o.valid; endproperty
  a_quiet: assert property (p_quiet) else $error("report with no event");
  property p_hot; hot_reset_i && !(|event_i) |=> !report_o.valid; endproperty
  a_hot: assert property (p_hot) else $error("report after hot reset");
endmodule // aer_bank_asserts

bind aer_uncorr_bank aer_bank_asserts u_chk (.clk_i, .srst_i, .hot_reset_i, .psel_i,
  .penable_i, .pwrite_i, .pslverr_o, .paddr_i, .prdata_o, .event_i, .report_o);

/* testbench/aer_root_model.sv */
// Root complex stand-in tallying error reports
`timescale 1ns/1ps
module aer_root_model (
  // Clock, reset and incoming reports
  input  wire logic                 clk_i,
  input  wire logic                 srst_i,
  input  wire aer_pkg::aer_report_t report_i,
  // Tallies, wrap at 256 which no run reaches
  output logic [7:0]                fatal_cnt_o, nonfatal_cnt_o
);
  // Report is a one-cycle pulse, so each valid cycle is one message
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      fatal_cnt_o <= 8'h00;
      nonfatal_cnt_o <= 8'h00;
    end else if (report_i.valid && report_i.fatal) begin
      fatal_cnt_o <= fatal_cnt_o + 8'h01;
    end else if (report_i.valid) begin
      nonfatal_cnt_o <= nonfatal_cnt_o + 8'h01;
    end
  end
endmodule // aer_root_model

/* testbench/aer_uncorrectable_mask_severity_test.sv */
// Self-checking bench for the uncorrectable error bank
`timescale 1ns/1ps
module aer_uncorrectable_mask_severity_test;
  logic clk_i, srst_i, hot_reset_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, irq_o, er;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, event_i, rd;
  logic [3:0] pstrb_i;
  logic [7:0] fcnt, ncnt, ef, en;
  aer_pkg::aer_report_t report_o;
  int num_errors = 0, n_tests = 0;
  localparam logic [31:0] DF = aer_pkg::SEV_RESET;
  // Rows: event bit, mask it, severity, expected {valid, fatal, index}
  int rb[14] = '{19, 19, 20, 4, 5, 13, 17, 18, 12, 16, 19, 14, 0, 20};
  bit rk[14] = '{0, 1, 1, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0};
  logic [31:0] rs[14] = '{DF, DF, DF, DF, DF, DF, DF, DF, DF, DF, 32'h0008_0000, '1, '1, DF};
  logic [6:0] rx[14] = '{7'h53, 7'h0, 7'h0, 7'h64, 7'h65, 7'h6D, 7'h71, 7'h72, 7'h4C,
    7'h50, 7'h73, 7'h0, 7'h0, 7'h54};
  aer_uncorr_bank DUT (.clk_i, .srst_i, .hot_reset_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .event_i, .report_o, .irq_o);
  aer_root_model u_root (.clk_i, .srst_i, .report_i(report_o), .fatal_cnt_o(fcnt),
    .nonfatal_cnt_o(ncnt));
  task chk(input logic [31:0] g, e);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // Bus cycle: request held until ready is seen at an edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  // Pulse one event bit and let its edge land
  task pulse(input int b);
    @(posedge clk_i) event_i <= 32'h1 << b;
    @(posedge clk_i) event_i <= 32'h0;
    #1;
  endtask
  task finish_test;
    $display("Errors %0d in %0d checks", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Whole run is well under a thousand cycles
  initial begin
    repeat (4000) @(posedge clk_i);
    num_errors++;
    finish_test;
  end
  initial begin
    {hot_reset_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, event_i, ef, en} = '0;
    srst_i = 1'b1;
    pstrb_i = 4'hF;
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
    apb(0, aer_pkg::OFS_SEVERITY, 0); chk(rd, 32'h0006_2030);
    apb(0, aer_pkg::OFS_MASK, 0); chk(rd, 32'h0);
    apb(1, aer_pkg::OFS_SEVERITY, '1); apb(0, aer_pkg::OFS_SEVERITY, 0); chk(rd, 32'h001F_3031);
    apb(1, aer_pkg::OFS_MASK, '1); apb(0, aer_pkg::OFS_MASK, 0); chk(rd, 32'h001F_3031);
    apb(0, 12'h200, 0); chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    apb(1, aer_pkg::OFS_IRQ_MASK, 3);
    foreach (rb[i]) begin
      apb(1, aer_pkg::OFS_MASK, rk[i] ? 32'h1 << rb[i] : 32'h0);
      apb(1, aer_pkg::OFS_SEVERITY, rs[i]);
      pulse(rb[i]);
      chk({25'h0, report_o}, {25'h0, rx[i]});
      chk({31'h0, irq_o}, {31'h0, rx[i][6]});
      apb(0, aer_pkg::OFS_STATUS, 0); chk(rd, rx[i][6] ? 32'h1 << rb[i] : 32'h0);
      apb(1, aer_pkg::OFS_STATUS, '1);
      apb(1, aer_pkg::OFS_IRQ_STAT, 3);
      ef += {7'h0, rx[i][5]};
      en += {7'h0, rx[i][6] & !rx[i][5]};
    end
    chk({fcnt, ncnt}, {ef, en});
    apb(1, aer_pkg::OFS_IRQ_MASK, 0); pulse(13); chk({31'h0, irq_o}, 32'h0);
    apb(1, aer_pkg::OFS_MASK, 32'h10);
    @(posedge clk_i) hot_reset_i <= 1'b1;
    @(posedge clk_i) hot_reset_i <= 1'b0;
    apb(0, aer_pkg::OFS_STATUS, 0); chk(rd, 32'h2000);
    apb(0, aer_pkg::OFS_MASK, 0); chk(rd, 32'h10);
    apb(0, aer_pkg::OFS_IRQ_STAT, 0); chk(rd, 32'h0);
    @(posedge clk_i) srst_i <= 1'b1;
    @(posedge clk_i) srst_i <= 1'b0;
    apb(0, aer_pkg::OFS_MASK, 0); chk(rd, 32'h0);
    finish_test;
  end
endmodule // aer_uncorrectable_mask_severity_test
